// File: core/lpmb_defs.svh
// Offsets, field positions, reset values and timing constants
`ifndef LPMB_DEFS_SVH
`define LPMB_DEFS_SVH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define LPMB_ADDR_CTRL 8'h00
`define LPMB_ADDR_LEVEL 8'h04
`define LPMB_ADDR_FREQ 8'h38
`define LPMB_ADDR_STATUS 8'h08
`define LPMB_ADDR_RESET 8'h60
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define LPMB_BIT_NOT_STANDBY_BIT 0
`define LPMB_BIT_BOOST_EN 1
`define LPMB_BIT_AUTOLOAD 2
`define LPMB_BIT_LED_EN 3
`define LPMB_FREQ_HI 2
`define LPMB_FREQ_MID 1
`define LPMB_FREQ_LO 0
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LPMB_CTRL_RST 4'h4
`define LPMB_LEVEL_RST 8'h3f
`define LPMB_FREQ_RST 3'h7
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LPMB_CLK_HZ 20000000
`define LPMB_DELAY_MS 10
`define LPMB_DELAY_CYC (`LPMB_CLK_HZ / 1000 * `LPMB_DELAY_MS)
`define LPMB_MINPULSE_NS 25
`define LPMB_CLK_NS 50
`define LPMB_MINPULSE_CYC \
  ((`LPMB_MINPULSE_NS + `LPMB_CLK_NS - 1) / `LPMB_CLK_NS)
`define LPMB_DIV_2M 10
`define LPMB_DIV_167M 12
`define LPMB_DIV_1M 20
`define LPMB_DUTY_NUM 7
`define LPMB_DUTY_DEN 8
`define LPMB_RESP_OKAY 2'h0
`define LPMB_RESP_SLVERR 2'h2
`endif

// File: core/lpmb_pkg.sv
// Types shared by the mode sequencer and boost control
package lpmb_pkg;
  typedef enum logic [4:0] {
    LPMB_RESET = 5'h01,
    LPMB_STANDBY = 5'h02,
    LPMB_STARTUP = 5'h04,
    LPMB_BOOST_START = 5'h08,
    LPMB_NORMAL = 5'h10
  } lpmb_mode_t;
endpackage

// File: core/lpmb_ctrl.sv
// Operating-mode sequencer and boost converter digital control
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "lpmb_defs.svh"

module lpmb_ctrl
  import lpmb_pkg::*;
#(
  parameter int DELAY_CYC = `LPMB_DELAY_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Analog status
  input wire logic por_active,
  input wire logic thermal_shutdown,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power control
  output logic bias_enable,
  output logic boost_run,
  output logic boost_pfm,
  output logic boost_switch,
  output logic active_load_en,
  output logic [7:0] boost_level,
  output logic led_enable
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [3:0] ctrl;
  logic [7:0] level;
  logic [2:0] freq_sel;
  lpmb_mode_t mode;
  logic [23:0] delay_cnt;
  logic soft_rst;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [4:0] per_cnt;
  logic [4:0] period;
  logic [4:0] on_max;
  logic [4:0] on_min;
  logic dev_rst;
  logic not_standby_bit;
  logic boost_en_bit;
  logic wr_go;
  logic wr_ok;

  assign dev_rst = !aresetn || por_active || soft_rst;
  assign not_standby_bit = ctrl[`LPMB_BIT_NOT_STANDBY_BIT];
  assign boost_en_bit = ctrl[`LPMB_BIT_BOOST_EN];
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = (aw_addr == `LPMB_ADDR_CTRL) ||
                 (aw_addr == `LPMB_ADDR_LEVEL) ||
                 (aw_addr == `LPMB_ADDR_FREQ) ||
                 (aw_addr == `LPMB_ADDR_RESET);

  // --------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LPMB_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      // An unmapped address is refused and leaves every register as it was
      s_axi_bresp <= wr_ok ? `LPMB_RESP_OKAY : `LPMB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Any data written to the reset register
  // The pulse lands on the same edge as the response is raised; the bus logic
  // ignores it, so the response still completes across the device reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_go && (aw_addr == `LPMB_ADDR_RESET);
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  // Defaults on every reset source
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      ctrl <= `LPMB_CTRL_RST;
      level <= `LPMB_LEVEL_RST;
      freq_sel <= `LPMB_FREQ_RST;
    end else if (wr_go && w_strb[0]) begin
      case (aw_addr)
        `LPMB_ADDR_CTRL: begin
          ctrl <= w_data[3:0];
        end
        `LPMB_ADDR_LEVEL: begin
          level <= w_data[7:0];
        end
        `LPMB_ADDR_FREQ: begin
          freq_sel <= w_data[2:0];
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LPMB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `LPMB_RESP_OKAY;
      case (s_axi_araddr)
        `LPMB_ADDR_CTRL: begin
          s_axi_rdata <= {28'h0, ctrl};
        end
        `LPMB_ADDR_LEVEL: begin
          s_axi_rdata <= {24'h0, level};
        end
        `LPMB_ADDR_FREQ: begin
          s_axi_rdata <= {29'h0, freq_sel};
        end
        // Status is read only: thermal input, soft-start flag, mode code
        `LPMB_ADDR_STATUS: begin
          s_axi_rdata <= {25'h0, thermal_shutdown, boost_pfm, mode};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `LPMB_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Mode sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      mode <= LPMB_RESET;
      delay_cnt <= 24'h000000;
    end else begin
      case (mode)
        LPMB_RESET: begin
          mode <= LPMB_STANDBY;
        end
        // Held while the bit is low
        LPMB_STANDBY: begin
          delay_cnt <= 24'h000000;
          if (not_standby_bit) begin
            mode <= LPMB_STARTUP;
          end
        end
        LPMB_STARTUP: begin
          if (!not_standby_bit) begin
            mode <= LPMB_STANDBY;
          end else if (thermal_shutdown) begin
            delay_cnt <= 24'h000000;
          end else if (delay_cnt < 24'(DELAY_CYC - 1)) begin
            delay_cnt <= delay_cnt + 24'h000001;
          end else begin
            delay_cnt <= 24'h000000;
            mode <= boost_en_bit ? LPMB_BOOST_START : LPMB_NORMAL;
          end
        end
        LPMB_BOOST_START: begin
          if (!not_standby_bit) begin
            mode <= LPMB_STANDBY;
          end else if (thermal_shutdown) begin
            mode <= LPMB_STARTUP;
            delay_cnt <= 24'h000000;
          end else if (!boost_en_bit) begin
            mode <= LPMB_NORMAL;
          end else if (delay_cnt < 24'(DELAY_CYC - 1)) begin
            delay_cnt <= delay_cnt + 24'h000001;
          end else begin
            mode <= LPMB_NORMAL;
          end
        end
        LPMB_NORMAL: begin
          delay_cnt <= 24'h000000;
          if (!not_standby_bit) begin
            mode <= LPMB_STANDBY;
          end else if (thermal_shutdown) begin
            mode <= LPMB_STARTUP;
          // Enable written high in normal
          // Converter still off here means this enable has had no soft start
          end else if (boost_en_bit && !boost_run) begin
            mode <= LPMB_BOOST_START;
          end
        end
        default: begin
          mode <= LPMB_RESET;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Power and output control
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      bias_enable <= 1'b0;
      boost_run <= 1'b0;
      boost_pfm <= 1'b0;
      led_enable <= 1'b0;
      active_load_en <= 1'b0;
      boost_level <= `LPMB_LEVEL_RST;
    end else begin
      bias_enable <= (mode == LPMB_STARTUP) ||
                     (mode == LPMB_BOOST_START) || (mode == LPMB_NORMAL);
      // Converter follows enable
      // Normal mode only keeps a converter that is already running, so a
      // late enable always passes through soft start before any PWM pulse.
      boost_run <= boost_en_bit &&
                   ((mode == LPMB_BOOST_START) ||
                    ((mode == LPMB_NORMAL) && boost_run));
      boost_pfm <= boost_en_bit && (mode == LPMB_BOOST_START);
      led_enable <= ctrl[`LPMB_BIT_LED_EN] && (mode == LPMB_NORMAL);
      active_load_en <= ctrl[`LPMB_BIT_AUTOLOAD] && boost_run;
      // Thermometer code passes to the divider
      boost_level <= level;
    end
  end

  // --------------------------------------------------------------------
  // Switch timing
  // --------------------------------------------------------------------
  // Priority frequency decode
  always_comb begin
    if (freq_sel[`LPMB_FREQ_HI]) begin
      period = 5'(`LPMB_DIV_2M);
    end else if (freq_sel[`LPMB_FREQ_MID]) begin
      period = 5'(`LPMB_DIV_167M);
    end else begin
      period = 5'(`LPMB_DIV_1M);
    end
    // Duty limit as fraction of period
    on_max = 5'((32'(period) * `LPMB_DUTY_NUM) / `LPMB_DUTY_DEN);
    // Minimum pulse, rounded up to whole cycles
    on_min = 5'(`LPMB_MINPULSE_CYC);
  end

  // PFM is emulated by one minimum pulse in every switching period;
  // the analog loop really sets the on time, this only bounds it.
  always_ff @(posedge aclk) begin
    if (dev_rst || !boost_run) begin
      per_cnt <= 5'h00;
      boost_switch <= 1'b0;
    end else begin
      per_cnt <= (per_cnt >= period - 5'h01) ? 5'h00 : per_cnt + 5'h01;
      if (boost_pfm) begin
        boost_switch <= per_cnt < on_min;
      end else begin
        boost_switch <= per_cnt < on_max;
      end
    end
  end

endmodule // lpmb_ctrl

// File: testbench/lpmb_ctrl_checker.sv
// Assertion checker for the mode sequencer and boost control
`timescale 1ns/1ns
module lpmb_ctrl_checker #(
  parameter int DELAY_CYC = 20
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Analog status
  input wire logic por_active,
  input wire logic thermal_shutdown,
  // Power control
  input wire logic bias_enable,
  input wire logic boost_run,
  input wire logic boost_pfm,
  input wire logic boost_switch,
  input wire logic led_enable,
  input wire logic [7:0] boost_level
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Switch on-time counter
  // ----------------------------------------------------------------
  logic [7:0] hi_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !boost_switch) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_por_hold;
    por_active [*2] |=> !bias_enable && !boost_run && boost_level == 8'h3f;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("por hold");
  property p_por_release; $fell(por_active) |-> !bias_enable [*2]; endproperty
  a_por_release: assert property (p_por_release) else $error("standby");
  property p_pfm_led; boost_pfm |-> !led_enable; endproperty
  a_pfm_led: assert property (p_pfm_led) else $error("led in pfm");
  property p_standby_off;
    !bias_enable [*2] |-> !boost_run && !led_enable && !boost_switch;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("off");
  property p_pfm_hold; $rose(boost_pfm) |=> boost_pfm [*8]; endproperty
  a_pfm_hold: assert property (p_pfm_hold) else $error("pfm short");
  property p_run_pfm; $rose(boost_run) |-> boost_pfm; endproperty
  a_run_pfm: assert property (p_run_pfm) else $error("no pfm start");
  // Seventeen is 7/8 of the longest period, 20 cycles
  property p_duty; boost_switch |-> hi_cnt < 8'h11; endproperty
  a_duty: assert property (p_duty) else $error("duty limit");
  property p_pulse_each;
    boost_run && !boost_pfm && !boost_switch
      |-> ##[1:24] (boost_switch || !boost_run || boost_pfm);
  endproperty
  a_pulse_each: assert property (p_pulse_each) else $error("skip");
  property p_thermal;
    thermal_shutdown |-> ##2 (!boost_run && !led_enable);
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal run");
  c_pfm: cover property ($rose(boost_pfm));
  c_thermal: cover property ($rose(thermal_shutdown));
  c_por: cover property ($fell(por_active));
endmodule // lpmb_ctrl_checker

bind lpmb_ctrl lpmb_ctrl_checker #(.DELAY_CYC(DELAY_CYC)) u_chk (
  .aclk, .aresetn, .por_active, .thermal_shutdown, .bias_enable,
  .boost_run, .boost_pfm, .boost_switch, .led_enable, .boost_level
);

// File: testbench/testbench.sv
// Self-checking bench for the mode sequencer and boost control
`timescale 1ns/1ns
`include "lpmb_defs.svh"
module testbench;
  localparam int D = 20;
  localparam int SW = 0;
  localparam int PFM = 3;
  localparam int ALD = 5;
  localparam logic [1:0] OK = `LPMB_RESP_OKAY;
  localparam logic [1:0] ERR = `LPMB_RESP_SLVERR;
  logic aclk, aresetn, por_active, thermal_shutdown;
  logic [7:0] s_axi_awaddr, s_axi_araddr, boost_level;
  logic [31:0] s_axi_wdata, s_axi_rdata, lv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, led_enable;
  logic bias_enable, boost_run, boost_pfm, boost_switch, active_load_en;
  logic [5:0] obs;
  int failures, compares, n, p;
  int fs[5] = '{7, 3, 1, 4, 2};
  int fp[5] = '{10, 12, 20, 10, 12};
  assign obs = {active_load_en, led_enable, boost_pfm, boost_run,
                bias_enable, boost_switch};
  lpmb_ctrl #(.DELAY_CYC(D)) DUT (
    .aclk, .aresetn, .por_active, .thermal_shutdown, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .bias_enable, .boost_run, .boost_pfm, .boost_switch,
    .active_load_en, .boost_level, .led_enable
  );
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tmo();
    failures++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Each bus task starts on a fresh edge so no signal is driven twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int k;
    logic aw, w;
    @(posedge aclk);
    k = 0;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (!s_axi_bvalid && k < 50);
    s_axi_bready <= 1'b0;
    if (k >= 50) tmo();
    chk(32'(s_axi_bresp), 32'(e));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] e);
    int k;
    @(posedge aclk);
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 50);
    s_axi_rready <= 1'b0;
    if (k >= 50) tmo();
    chk(32'(s_axi_rresp), 32'(e));
    if (e === OK) chk(s_axi_rdata, x);
  endtask
  task automatic wt(input int i, input logic v, output int c);
    c = 0;
    while (obs[i] !== v && c < 2000) begin
      @(negedge aclk);
      c++;
    end
    if (c >= 2000) tmo();
  endtask
  task automatic per(output int q);
    int a;
    wt(SW, 1'b0, a);
    wt(SW, 1'b1, a);
    wt(SW, 1'b0, a);
    wt(SW, 1'b1, q);
    q = q + a;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, por_active, thermal_shutdown, s_axi_awvalid} = 4'h0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LPMB_ADDR_CTRL, 32'h4, OK);
    rd(`LPMB_ADDR_LEVEL, 32'h3f, OK);
    rd(`LPMB_ADDR_FREQ, 32'h7, OK);
    rd(`LPMB_ADDR_STATUS, 32'h2, OK);
    rd(`LPMB_ADDR_RESET, 32'h0, ERR);
    rd(8'h1c, 32'h0, ERR);
    wr(8'h1c, 32'h1, ERR);
    wr(`LPMB_ADDR_LEVEL, 32'h0f, OK);
    wr(`LPMB_ADDR_CTRL, 32'h0e, OK);
    repeat (D + 5) @(negedge aclk);
    chk(32'(obs[4:0]), 32'h0);
    wr(`LPMB_ADDR_CTRL, 32'h0f, OK);
    wt(PFM, 1'b1, n);
    chk(32'(n >= D - 4 && n <= D + 4), 32'h1);
    wt(PFM, 1'b0, n);
    chk(32'(n >= D - 4 && n <= D + 4), 32'h1);
    repeat (2) @(negedge aclk);
    chk({24'h0, boost_level}, 32'h0f);
    chk(32'(obs[ALD:PFM]), 32'h6);
    foreach (fs[i]) begin
      wr(`LPMB_ADDR_FREQ, 32'(fs[i]), OK);
      per(p);
      per(p);
      chk(32'(p), 32'(fp[i]));
    end
    for (int i = 0; i < 9; i++) begin
      lv = 32'((9'h1 << i) - 9'h1);
      wr(`LPMB_ADDR_LEVEL, lv, OK);
      rd(`LPMB_ADDR_LEVEL, lv, OK);
      chk({24'h0, boost_level}, lv);
    end
    wr(`LPMB_ADDR_CTRL, 32'h0b, OK);
    repeat (2) @(negedge aclk);
    chk(32'(obs[ALD]), 32'h0);
    wr(`LPMB_ADDR_CTRL, 32'h0d, OK);
    repeat (2) @(negedge aclk);
    chk(32'(obs[ALD:2]), 32'h4);
    wr(`LPMB_ADDR_CTRL, 32'h0f, OK);
    wt(PFM, 1'b1, n);
    chk(32'(n <= 4), 32'h1);
    wt(PFM, 1'b0, n);
    @(posedge aclk);
    thermal_shutdown <= 1'b1;
    repeat (3) @(negedge aclk);
    chk(32'(obs[4:2]), 32'h0);
    rd(`LPMB_ADDR_STATUS, 32'h44, OK);
    thermal_shutdown <= 1'b0;
    wt(PFM, 1'b1, n);
    chk(32'(n <= D + 4), 32'h1);
    wt(PFM, 1'b0, n);
    wr(`LPMB_ADDR_CTRL, 32'h0e, OK);
    repeat (3) @(negedge aclk);
    chk(32'(obs[4:0]), 32'h0);
    wr(`LPMB_ADDR_CTRL, 32'h0f, OK);
    wr(`LPMB_ADDR_RESET, 32'ha5, OK);
    rd(`LPMB_ADDR_CTRL, 32'h4, OK);
    rd(`LPMB_ADDR_LEVEL, 32'h3f, OK);
    wr(`LPMB_ADDR_LEVEL, 32'h07, OK);
    @(posedge aclk);
    por_active <= 1'b1;
    repeat (5) @(posedge aclk);
    por_active <= 1'b0;
    rd(`LPMB_ADDR_LEVEL, 32'h3f, OK);
    rd(`LPMB_ADDR_STATUS, 32'h2, OK);
    wr(`LPMB_ADDR_CTRL, 32'h09, OK);
    repeat (D + 6) @(negedge aclk);
    chk(32'(obs[4:1]), 32'h9);
    print_verdict();
  end
endmodule // testbench
